// [src/exc_defs.svh]
`ifndef EXC_DEFS_SVH
`define EXC_DEFS_SVH

// Vector numbers
`define VEC_ACCESS_FAULT 8'h02
`define VEC_ADDR_ERROR 8'h03
`define VEC_ILLEGAL 8'h04
`define VEC_DIV_ZERO 8'h05
`define VEC_BOUND 8'h06
`define VEC_COND_TRAP 8'h07
`define VEC_LINE_A 8'h0A
`define VEC_TRAP_BASE 8'h20

// Processor phase codes while halted, running normally and handling an exception
`define PHASE_HALTED 4'h5
`define PHASE_NORMAL 4'h0
`define PHASE_EXCEPTION 4'hC

// Opcode field positions
`define OPC_LINE_HI 15
`define OPC_LINE_LO 12
`define OPC_LINE_A 4'hA

// Status word field positions
`define PSW_TRACE_HI 15
`define PSW_TRACE_LO 14
`define PSW_SUPER 13
`define PSW_RESET 16'h2700

// Writeback slots held in the frame
`define WB_SLOTS 3

`endif

// [src/exc_pkg.sv]
package exc_pkg;
    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_DRAIN = 3'b001,
        ST_WAIT_FETCH = 3'b010,
        ST_STACK = 3'b011,
        ST_HALT = 3'b100
    } exc_state_t;

    typedef enum logic [1:0] {
        FR_NONE = 2'b00,
        FR_FAULT = 2'b01,
        FR_TRAP = 2'b10,
        FR_SHORT = 2'b11
    } frame_kind_t;
endpackage

// [src/exc_unit.sv]
`timescale 1ns/100ps
`include "exc_defs.svh"

module exc_unit (
    input wire logic clock,
    input wire logic rst_n,
    // Pipeline / execution side
    input wire logic [15:0] opcode,
    input wire logic opcode_valid,
    input wire logic opcode_illegal,
    input wire logic ctl_move_bad_reg,
    input wire logic [31:0] insn_pc,
    input wire logic [31:0] next_pc,
    input wire logic trap_uncond,
    input wire logic [3:0] trap_number,
    input wire logic divide_zero,
    input wire logic bound_fail,
    input wire logic cond_trap_fire,
    input wire logic older_pending,
    input wire logic older_exception,
    input wire logic exec_idle,
    input wire logic fetch_req,
    input wire logic [31:0] fetch_addr,
    input wire logic fetch_used,
    input wire logic flow_change,
    input wire logic [15:0] processor_state_word,
    input wire logic [15:0] multi_move_state,
    input wire logic [31:0] wb_data0,
    input wire logic [31:0] wb_data1,
    input wire logic [31:0] wb_data2,
    input wire logic [2:0] wb_valid,
    input wire logic rte_reload,
    input wire logic stack_done,
    // Bus side
    input wire logic bus_cycle_end,
    input wire logic bus_is_write,
    input wire logic bus_is_fetch,
    input wire logic bus_is_line,
    input wire logic bus_first_beat,
    input wire logic bus_beat_needed,
    input wire logic bus_is_bkpt_ack,
    input wire logic [31:0] bus_addr,
    input wire logic fetch_bus_busy,
    input wire logic internal_fault,
    input wire logic transfer_error_ack,
    // Outputs
    output logic exec_flush,
    output logic exc_start,
    output logic [7:0] exc_vector,
    output exc_pkg::frame_kind_t frame_kind,
    output logic [31:0] frame_pc,
    output logic [31:0] frame_insn_addr,
    output logic [31:0] frame_fault_addr,
    output logic [15:0] frame_psw,
    output logic [15:0] frame_move_state,
    output logic [31:0] frame_wb0,
    output logic [31:0] frame_wb1,
    output logic [31:0] frame_wb2,
    output logic [2:0] frame_wb_valid,
    output logic [15:0] new_psw,
    output logic fetch_grant,
    output logic mem_write_block,
    output logic [3:0] processor_phase_outputs
);
    import exc_pkg::*;

    // ----------------------------------------
    // Input synchronisers for pins
    // ----------------------------------------
    logic tea_meta_q, tea_q;
    logic bus_end_meta_q, bus_end_q;

    // Bus pins come from the external domain; cycle end and error pass two flops before use
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tea_meta_q <= 1'b0;
            tea_q <= 1'b0;
            bus_end_meta_q <= 1'b0;
            bus_end_q <= 1'b0;
        end else begin
            tea_meta_q <= transfer_error_ack;
            tea_q <= tea_meta_q;
            bus_end_meta_q <= bus_cycle_end;
            bus_end_q <= bus_end_meta_q;
        end
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Status word copy with supervisor set and both trace bits cleared
    function automatic logic [15:0] enter_super(input logic [15:0] psw);
        logic [15:0] r;
        r = psw;
        r[`PSW_SUPER] = 1'b1;
        r[`PSW_TRACE_HI] = 1'b0;
        r[`PSW_TRACE_LO] = 1'b0;
        return r;
    endfunction

    // ----------------------------------------
    // Fault detection
    // ----------------------------------------
    exc_state_t state_q;
    logic fault_pend_q, addr_err_pend_q, pf_err_q, data_fault_q;
    logic [31:0] fault_addr_q, err_fetch_addr_q;
    logic bus_err_now, data_fault_now, odd_fetch, stacking_fault, halt_now;

    // Error on bus raises a data fault only for writes, single reads, first beat, or needed beats
    assign bus_err_now = tea_q & bus_end_q;
    // A breakpoint acknowledge ended by an error is an illegal instruction, not a fault
    assign data_fault_now = (bus_err_now & ~bus_is_fetch & ~bus_is_bkpt_ack
        & (bus_is_write | ~bus_is_line | bus_first_beat | bus_beat_needed))
        | internal_fault;
    assign odd_fetch = fetch_req & fetch_addr[0];
    // Fault or odd fetch while stacking a fault frame, or during return reload
    assign stacking_fault = (state_q == ST_STACK && frame_kind == FR_FAULT)
        | rte_reload;
    assign halt_now = stacking_fault & (bus_err_now | internal_fault | odd_fetch);

    // Prefetch is never issued to an odd address, nor after the first halted cycle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            fetch_grant <= 1'b0;
        end else begin
            fetch_grant <= fetch_req & ~fetch_addr[0] & (state_q != ST_HALT);
        end
    end

    // Prefetch bus errors held until the words are used
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pf_err_q <= 1'b0;
        end else if (bus_err_now & bus_is_fetch) begin
            pf_err_q <= 1'b1;
        end else if (flow_change | (state_q == ST_STACK)) begin
            pf_err_q <= 1'b0;
        end
    end

    // Pending access fault; older instruction exceptions cancel it (set wins if both in one cycle)
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            fault_pend_q <= 1'b0;
            data_fault_q <= 1'b0;
            fault_addr_q <= 32'h0000_0000;
        end else if (data_fault_now | (pf_err_q & fetch_used)) begin
            fault_pend_q <= 1'b1;
            data_fault_q <= data_fault_now;
            fault_addr_q <= bus_addr;
        end else if (older_exception | (state_q == ST_STACK)) begin
            fault_pend_q <= 1'b0;
        end
    end

    // Pending address error with its fetch address
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            addr_err_pend_q <= 1'b0;
            err_fetch_addr_q <= 32'h0000_0000;
        end else if (odd_fetch & (state_q == ST_RUN)) begin
            addr_err_pend_q <= 1'b1;
            err_fetch_addr_q <= {fetch_addr[31:1], 1'b0};
        end else if (older_exception | (state_q == ST_STACK)) begin
            addr_err_pend_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // Instruction exception decode
    // ----------------------------------------
    logic line_a, illegal, trap_any;
    logic [7:0] trap_vec;
    assign line_a = opcode_valid &
        (opcode[`OPC_LINE_HI:`OPC_LINE_LO] == `OPC_LINE_A);
    assign illegal = (opcode_valid & (opcode_illegal | ctl_move_bad_reg))
        | (bus_is_bkpt_ack & bus_end_q);
    assign trap_any = trap_uncond | divide_zero | bound_fail | cond_trap_fire;

    // Fixed ranking: fault, address error, then line A, illegal, traps
    always_comb begin
        trap_vec = 8'h00;
        if (line_a) begin
            trap_vec = `VEC_LINE_A;
        end else if (illegal) begin
            trap_vec = `VEC_ILLEGAL;
        end else if (trap_uncond) begin
            trap_vec = `VEC_TRAP_BASE + {4'h0, trap_number};
        end else if (divide_zero) begin
            trap_vec = `VEC_DIV_ZERO;
        end else if (bound_fail) begin
            trap_vec = `VEC_BOUND;
        end else if (cond_trap_fire) begin
            trap_vec = `VEC_COND_TRAP;
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    logic any_fault;
    assign any_fault = fault_pend_q | addr_err_pend_q;

    // Faults wait for older work to drain; data faults also for the fetch cycle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_q <= ST_RUN;
        end else if (halt_now) begin
            state_q <= ST_HALT;
        end else begin
            case (state_q)
                ST_RUN: begin
                    if (any_fault | line_a | illegal | trap_any) begin
                        state_q <= ST_DRAIN;
                    end
                end
                ST_DRAIN: begin
                    if (!any_fault) begin
                        state_q <= exec_idle ? ST_STACK : ST_DRAIN;
                    end else if (!older_pending && exec_idle) begin
                        state_q <= (data_fault_q & fetch_bus_busy)
                            ? ST_WAIT_FETCH : ST_STACK;
                    end
                end
                ST_WAIT_FETCH: begin
                    if (!fetch_bus_busy) begin
                        state_q <= ST_STACK;
                    end
                end
                ST_STACK: begin
                    if (stack_done) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_HALT: state_q <= ST_HALT;
                default: state_q <= ST_RUN;
            endcase
        end
    end

    // Execution unit held idle whenever an exception is being handled
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            exec_flush <= 1'b0;
        end else begin
            // Raised on the detection edge so the flush precedes the start pulse
            exec_flush <= (state_q != ST_RUN) | any_fault
                | ((state_q == ST_RUN) & (line_a | illegal | trap_any));
        end
    end

    // Memory writes blocked while halted
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            mem_write_block <= 1'b0;
            processor_phase_outputs <= `PHASE_NORMAL;
        end else begin
            mem_write_block <= (state_q == ST_HALT) | halt_now;
            processor_phase_outputs <= (state_q == ST_HALT || halt_now) ? `PHASE_HALTED
                : (state_q == ST_RUN) ? `PHASE_NORMAL : `PHASE_EXCEPTION;
        end
    end

    // ----------------------------------------
    // Frame capture at entry to stacking
    // ----------------------------------------
    logic enter_stack;
    logic [7:0] tvec_q;
    logic [31:0] tpc_q, tinsn_q;
    assign enter_stack = (state_q != ST_STACK) && (state_q != ST_HALT) && !halt_now
        && ((state_q == ST_DRAIN && exec_idle && (!any_fault || !older_pending)
        && !(any_fault && data_fault_q && fetch_bus_busy))
        || (state_q == ST_WAIT_FETCH && !fetch_bus_busy));

    // Latch only the highest instruction exception when first seen
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tvec_q <= 8'h00;
            tpc_q <= 32'h0000_0000;
            tinsn_q <= 32'h0000_0000;
        end else if (state_q == ST_RUN && (line_a | illegal | trap_any)) begin
            tvec_q <= trap_vec;
            tinsn_q <= insn_pc;
            tpc_q <= (line_a | illegal) ? insn_pc : next_pc;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            exc_start <= 1'b0;
            exc_vector <= 8'h00;
            frame_kind <= FR_NONE;
            frame_pc <= 32'h0000_0000;
            frame_insn_addr <= 32'h0000_0000;
            frame_fault_addr <= 32'h0000_0000;
            frame_psw <= `PSW_RESET;
            frame_move_state <= 16'h0000;
            frame_wb0 <= 32'h0000_0000;
            frame_wb1 <= 32'h0000_0000;
            frame_wb2 <= 32'h0000_0000;
            frame_wb_valid <= 3'b000;
            new_psw <= `PSW_RESET;
        end else begin
            exc_start <= enter_stack;
            if (enter_stack) begin
                frame_psw <= processor_state_word;
                new_psw <= enter_super(processor_state_word);
                if (fault_pend_q) begin
                    exc_vector <= `VEC_ACCESS_FAULT;
                    frame_kind <= FR_FAULT;
                    frame_pc <= insn_pc;
                    frame_fault_addr <= fault_addr_q;
                    frame_move_state <= multi_move_state;
                    frame_wb0 <= wb_data0;
                    frame_wb1 <= wb_data1;
                    frame_wb2 <= wb_data2;
                    frame_wb_valid <= wb_valid;
                end else if (addr_err_pend_q) begin
                    exc_vector <= `VEC_ADDR_ERROR;
                    frame_kind <= FR_FAULT;
                    frame_pc <= insn_pc;
                    frame_insn_addr <= insn_pc;
                    frame_fault_addr <= err_fetch_addr_q;
                    frame_wb_valid <= 3'b000;
                end else begin
                    exc_vector <= tvec_q;
                    frame_pc <= tpc_q;
                    frame_insn_addr <= tinsn_q;
                    frame_kind <= (tvec_q[7:4] == 4'h2 || tvec_q == `VEC_ILLEGAL
                        || tvec_q == `VEC_LINE_A) ? FR_SHORT : FR_TRAP;
                end
            end
        end
    end
endmodule

// [tb/exc_unit_assertions.sv]
`timescale 1ns/100ps
`include "exc_defs.svh"
// ------
// Port checker
// ------
module exc_unit_checker (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic exc_start,
    input wire logic [7:0] exc_vector,
    input wire exc_pkg::frame_kind_t frame_kind,
    input wire logic [15:0] frame_psw,
    input wire logic [15:0] new_psw,
    input wire logic [31:0] frame_fault_addr,
    input wire logic exec_flush,
    input wire logic fetch_req,
    input wire logic [31:0] fetch_addr,
    input wire logic fetch_grant,
    input wire logic mem_write_block,
    input wire logic [3:0] processor_phase_outputs
);
    import exc_pkg::*;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    // Steps: pipeline flushed before the start pulse; halt seen twice
    sequence flushed;
        $past(exec_flush);
    endsequence
    sequence halted_twice;
        (processor_phase_outputs == `PHASE_HALTED) [*2];
    endsequence
    a_start_one_cycle: assert property (exc_start |=> !exc_start)
        else $error("exc_start held too long");
    a_flush_first: assert property (exc_start |-> flushed)
        else $error("exception started without flush");
    a_psw_super: assert property (exc_start |-> new_psw == {3'b001, frame_psw[12:0]})
        else $error("new status word wrong");
    a_fault_vector: assert property (exc_start && frame_kind == FR_FAULT |->
        exc_vector inside {8'h02, 8'h03})
        else $error("fault frame with wrong vector");
    a_trap_frame: assert property (exc_start && exc_vector inside {8'h05, 8'h06, 8'h07} |->
        frame_kind == FR_TRAP)
        else $error("trap frame kind wrong");
    a_odd_refused: assert property (fetch_req && fetch_addr[0] && $past(fetch_req && fetch_addr[0])
        |-> !fetch_grant)
        else $error("odd prefetch granted");
    a_addr_even: assert property (exc_start && exc_vector == 8'h03 |-> !frame_fault_addr[0])
        else $error("address bit zero not cleared");
    a_halt_sticky: assert property (processor_phase_outputs == `PHASE_HALTED |=>
        $stable(processor_phase_outputs))
        else $error("halt left without reset");
    a_halt_quiet: assert property (halted_twice |-> mem_write_block && !fetch_grant)
        else $error("memory activity while halted");
endmodule

bind exc_unit exc_unit_checker exc_unit_checker_inst (.*);

// [tb/bus_responder.sv]
`timescale 1ns/100ps
// ------
// Far-side bus: ends a cycle promptly or late, errors on command
// ------
module bus_responder (
    input wire logic clock,
    input wire logic start,
    input wire logic write,
    input wire logic bkpt,
    input wire logic err,
    output logic bus_cycle_end,
    output logic transfer_error_ack,
    output logic bus_is_write,
    output logic bus_is_bkpt_ack,
    output logic [31:0] bus_addr
);
    // Qualifiers outlive the two-flop sync, then show garbage
    initial begin
        {bus_cycle_end, transfer_error_ack, bus_is_write, bus_is_bkpt_ack} = 4'h0;
        bus_addr = 32'h0;
        forever begin
            @(posedge clock);
            if (start) begin
                @(negedge clock);
                bus_is_write = write;
                bus_is_bkpt_ack = bkpt;
                bus_addr = 32'h0000_1000;
                repeat ($urandom_range(3)) @(negedge clock);
                bus_cycle_end = 1'b1;
                transfer_error_ack = err;
                @(negedge clock);
                bus_cycle_end = 1'b0;
                transfer_error_ack = 1'b0;
                repeat (4) @(negedge clock);
                {bus_is_write, bus_is_bkpt_ack} = 2'h0;
                bus_addr = ~bus_addr;
            end
        end
    end
endmodule

// [tb/testbench.sv]
`timescale 1ns/100ps
module testbench;
    import exc_pkg::*;
    logic clock = 0, rst_n = 0, opcode_valid = 0, opcode_illegal = 0, ctl_move_bad_reg = 0;
    logic trap_uncond = 0, divide_zero = 0, bound_fail = 0, cond_trap_fire = 0, stack_done = 0;
    logic older_pending = 0, older_exception = 0, exec_idle = 1, fetch_req = 0, fetch_used = 0;
    logic flow_change = 0, rte_reload = 0, internal_fault = 0, bus_is_fetch = 0, bus_is_line = 0;
    logic bus_first_beat = 0, bus_beat_needed = 0, fetch_bus_busy = 0;
    logic bus_start = 0, bus_wr = 0, bus_bk = 0, bus_err = 0;
    logic [15:0] opcode = 0, processor_state_word = 0, multi_move_state = 0;
    logic [31:0] insn_pc = 0, next_pc = 0, fetch_addr = 0, wb_data0 = 0, wb_data1 = 0, wb_data2 = 0;
    logic [3:0] trap_number = 0;
    logic [2:0] wb_valid = 0;
    logic bus_cycle_end, transfer_error_ack, bus_is_write, bus_is_bkpt_ack, exec_flush, exc_start;
    logic fetch_grant, mem_write_block;
    logic [31:0] bus_addr, frame_pc, frame_insn_addr, frame_fault_addr, frame_wb0, frame_wb1;
    logic [31:0] frame_wb2;
    logic [15:0] frame_psw, frame_move_state, new_psw;
    logic [7:0] exc_vector;
    logic [2:0] frame_wb_valid;
    logic [3:0] processor_phase_outputs;
    frame_kind_t frame_kind;
    int n_mismatch = 0, tests_run = 0, n_starts = 0, seen;
    logic [7:0] vec_tab [7] = '{8'h20, 8'h05, 8'h06, 8'h07, 8'h04, 8'h04, 8'h0A};

    exc_unit exc_unit_inst (.*);
    bus_responder bus_responder_inst (.clock, .start(bus_start), .write(bus_wr), .bkpt(bus_bk),
        .err(bus_err), .bus_cycle_end, .transfer_error_ack, .bus_is_write, .bus_is_bkpt_ack,
        .bus_addr);

    // 25 MHz clock and a count of start pulses
    always #20 clock = ~clock;
    always @(posedge clock) if (exc_start === 1'b1) n_starts++;

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Set one event at a falling edge; pulses drop one cycle later
    task automatic fire(input int k, input logic [3:0] n);
        trap_number = n;
        opcode_valid = 1'b1;
        opcode = {4'h4, 12'($urandom)};
        case (k)
            0: trap_uncond = 1'b1;
            1: divide_zero = 1'b1;
            2: bound_fail = 1'b1;
            3: cond_trap_fire = 1'b1;
            4: opcode_illegal = 1'b1;
            5: ctl_move_bad_reg = 1'b1;
            6: opcode = {4'hA, 12'($urandom)};
            default: internal_fault = 1'b1;
        endcase
        @(negedge clock);
        {trap_uncond, divide_zero, bound_fail, cond_trap_fire, internal_fault} = 5'h0;
    endtask

    task automatic wait_start;
        for (int i = 0; i < 40 && exc_start !== 1'b1; i++) @(posedge clock) #1;
        @(negedge clock);
    endtask

    // Level requests are withdrawn while stacking, else they would fire again
    task automatic take(input logic [7:0] vec);
        wait_start();
        check("vector", 32'(vec), 32'(exc_vector));
        check("new_psw", {16'h0, 3'b001, processor_state_word[12:0]}, 32'(new_psw));
        {opcode_illegal, ctl_move_bad_reg, opcode_valid, fetch_req} = 4'h0;
        opcode = 16'h0;
        stack_done = 1'b1;
        @(negedge clock);
        stack_done = 1'b0;
    endtask

    task automatic run_kind(input int k);
        logic [3:0] n;
        n = 4'($urandom_range(15));
        insn_pc = $urandom & ~32'h1;
        next_pc = insn_pc + 32'h4;
        processor_state_word = 16'($urandom) | 16'hC000;
        fire(k, n);
        take(vec_tab[k] + ((k == 0) ? {4'h0, n} : 8'h00));
        if (k < 4) check("frame_pc", next_pc, frame_pc);
        if (k inside {[1:3]}) check("insn_addr", insn_pc, frame_insn_addr);
    endtask

    task automatic bus(input logic wr, input logic bk, input logic er, input logic [7:0] vec);
        {bus_wr, bus_bk, bus_err, bus_start} = {wr, bk, er, 1'b1};
        @(negedge clock);
        bus_start = 1'b0;
        take(vec);
    endtask

    initial begin
        #(5000 * 40);
        n_mismatch++;
        summarize();
    end

    initial begin
        void'($urandom(96));
        repeat (6) @(negedge clock);
        rst_n = 1'b1;
        repeat (3) @(negedge clock);
        for (int k = 0; k < 7; k++) run_kind(k);
        repeat (20) run_kind($urandom_range(6));
        divide_zero = 1'b1;
        fire(2, 4'h0);
        take(8'h05);
        internal_fault = 1'b1;
        fire(0, 4'h3);
        take(8'h02);
        // Fault held back while older work completes
        older_pending = 1'b1;
        {wb_data0, multi_move_state, wb_valid} = {$urandom, 16'($urandom), 3'h7};
        fire(7, 4'h0);
        seen = n_starts;
        repeat (8) @(negedge clock);
        check("deferred", seen, n_starts);
        older_pending = 1'b0;
        take(8'h02);
        check("fault_pc", insn_pc, frame_pc);
        check("wb0", wb_data0, frame_wb0);
        check("move", 32'(multi_move_state), 32'(frame_move_state));
        fetch_addr = $urandom | 32'h1;
        fetch_req = 1'b1;
        take(8'h03);
        check("odd_addr", fetch_addr & ~32'h1, frame_fault_addr);
        check("odd_insn", insn_pc, frame_insn_addr);
        bus(1'b1, 1'b0, 1'b1, 8'h02);
        bus(1'b0, 1'b1, 1'b0, 8'h04);
        bus(1'b0, 1'b1, 1'b1, 8'h04);
        // Second fault or odd fetch while stacking a fault: halt until reset
        for (int c = 0; c < 2; c++) begin
            fire(7, 4'h0);
            wait_start();
            fetch_addr = 32'h0000_0003;
            fetch_req = c[0];
            fire(c[0] ? 1 : 7, 4'h0);
            repeat (4) @(negedge clock);
            check("halt", 32'h5, 32'(processor_phase_outputs));
            fire(1, 4'h0);
            seen = n_starts;
            repeat (10) @(negedge clock);
            check("halt_kept", 32'h5, 32'(processor_phase_outputs));
            check("no_start", seen, n_starts);
            check("write_block", 32'h1, 32'(mem_write_block));
            fetch_req = 1'b0;
            rst_n = 1'b0;
            repeat (3) @(negedge clock);
            rst_n = 1'b1;
            @(negedge clock);
            check("restart", 32'h0, 32'(processor_phase_outputs));
        end
        summarize();
    end
endmodule
